/* File: nfc_rx_status_apb.sv */
// apb slave front end: decode, one-wait access, read mux and read strobe
`timescale 1ns/1ps
`default_nettype none
module nfc_rx_status_apb
	import nfc_rx_status_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [7:0] irq_val,
	input wire logic [7:0] fifo_lo_val,
	input wire logic [7:0] fifo_hi_val,
	input wire logic [7:0] coll_val,
	input wire logic [7:0] ctrl_val,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq_read_pulse,
	output logic ctrl_wr_pulse
);
	logic [31:0] prdata_ff;
	logic pready_ff;
	logic pslverr_ff;
	logic rd_irq_ff;
	logic wr_ctrl_ff;
	wire access = psel && penable && !pready_ff;
	wire hit_irq = paddr == OFF_PT_IRQ;
	wire hit_lo = paddr == OFF_FIFO_LO;
	wire hit_hi = paddr == OFF_FIFO_HI;
	wire hit_col = paddr == OFF_COLL;
	wire hit_ctl = paddr == OFF_EVT_CTRL;
	wire mapped = hit_irq | hit_lo | hit_hi | hit_col | hit_ctl;
	wire [7:0] rd_byte = hit_irq ? irq_val : hit_lo ? fifo_lo_val : hit_hi ? fifo_hi_val :
		hit_col ? coll_val : hit_ctl ? ctrl_val : BYTE_RST;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			prdata_ff <= 32'h0000_0000;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			rd_irq_ff <= 1'b0;
			wr_ctrl_ff <= 1'b0;
		end else begin
			pready_ff <= access;
			pslverr_ff <= access && !mapped;
			prdata_ff <= (access && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
			rd_irq_ff <= access && !pwrite && hit_irq;
			wr_ctrl_ff <= access && pwrite && hit_ctl;
		end
	end
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign irq_read_pulse = rd_irq_ff;
	assign ctrl_wr_pulse = wr_ctrl_ff;
endmodule : nfc_rx_status_apb
`default_nettype wire

/* File: nfc_rx_status_irq_regs.sv */
// rx status bank: passive target events, fifo level, last byte info, collision position
// Function
// - target event register clears when read
// - bit 7 set on second field timer expiry
// - bit 6 set at four free slots
// - bit 5 set after clean collision avoidance
// - bit 4 set on auto-answered receive end
// - bit 3 set after automatic SENSF response
// - bit 1 Active*, bit 0 Active, bit 2 reserved
// - 10-bit fifo count, low byte, 0..512
// - count msbs, underflow, overflow in second byte
// - partial last byte bit count, bits 3..1
// - bit 0 flags missing parity, full byte
// - hard framing error leaves fields undefined
// - collision bytes count in bits 7..4
// - collision bit index in bits 3..1
// - bit 0 marks collision on parity
// - collisions recorded only in anticollision frames
// - only hard framing error marks corruption
`timescale 1ns/1ps
`default_nettype none
module nfc_rx_status_irq_regs
	import nfc_rx_status_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic second_field_wait_timer_expired,
	input wire logic [7:0] free_time_slot_number_count,
	input wire logic field_on_no_collision,
	input wire logic rx_end_auto_answered,
	input wire logic sensf_auto_response_sent,
	input wire logic target_reached_active_star,
	input wire logic target_reached_active,
	input wire logic fifo_push,
	input wire logic fifo_pop,
	input wire logic fifo_clear,
	input wire logic rx_frame_start,
	input wire logic rx_frame_end,
	input wire logic anticollision_frame,
	input wire logic [2:0] last_byte_bit_count,
	input wire logic last_byte_parity_absent,
	input wire logic hard_framing_error_flag,
	input wire logic collision_detect,
	input wire logic [3:0] collision_byte_index,
	input wire logic [2:0] collision_bit_index,
	input wire logic collision_on_parity_flag,
	output logic status_hard_error,
	output logic [7:0] irq_pending
);
	// ----------------------------------------------------------------
	// event register
	// ----------------------------------------------------------------
	logic [7:0] irq_ff;
	logic [7:0] nxt_irq;
	logic irq_read;
	logic ctrl_wr;
	logic slot_wl_armed_ff;
	logic [7:0] evt_en_ff;
	wire slot_at_level = free_time_slot_number_count == SLOT_WL_LEVEL;
	// fire once per arrival at the level, not every cycle while sitting there
	wire slot_wl_evt = slot_at_level && slot_wl_armed_ff;
	logic [7:0] evt_vec;
	always_comb begin
		evt_vec = IRQ_RST;
		evt_vec[BIT_FIELD_TIMER] = second_field_wait_timer_expired;
		evt_vec[BIT_SLOT_WL] = slot_wl_evt;
		evt_vec[BIT_APON] = field_on_no_collision;
		evt_vec[BIT_RXE_PTA] = rx_end_auto_answered;
		evt_vec[BIT_WU_F] = sensf_auto_response_sent;
		evt_vec[BIT_WU_ASTAR] = target_reached_active_star;
		evt_vec[BIT_WU_A] = target_reached_active;
	end
	// a read clears, but an event landing in the same cycle survives it
	assign nxt_irq = ((irq_read ? IRQ_RST : irq_ff) | (evt_vec & evt_en_ff));
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_ff <= IRQ_RST;
			slot_wl_armed_ff <= 1'b1;
		end else begin
			irq_ff <= nxt_irq;
			slot_wl_armed_ff <= !slot_at_level;
		end
	end
	// ----------------------------------------------------------------
	// event enable register (software writable, steers the latching)
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			evt_en_ff <= 8'hFB;
		end else if (ctrl_wr && pstrb[0]) begin
			evt_en_ff <= pwdata[7:0] & 8'hFB;
		end
	end
	// ----------------------------------------------------------------
	// fifo occupancy and flags
	// ----------------------------------------------------------------
	logic [FIFO_CNT_W-1:0] cnt_ff;
	logic [FIFO_CNT_W-1:0] nxt_cnt;
	logic unf_ff;
	logic ovr_ff;
	wire do_push = fifo_push && !fifo_pop;
	wire do_pop = fifo_pop && !fifo_push;
	wire push_full = do_push && (cnt_ff == FIFO_CNT_MAX);
	wire pop_empty = do_pop && (cnt_ff == CNT_RST);
	// saturate at both ends so the count never leaves 0..512
	assign nxt_cnt = fifo_clear ? CNT_RST :
		(do_push && !push_full) ? cnt_ff + 10'h001 :
		(do_pop && !pop_empty) ? cnt_ff - 10'h001 : cnt_ff;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_ff <= CNT_RST;
			unf_ff <= 1'b0;
			ovr_ff <= 1'b0;
		end else begin
			cnt_ff <= nxt_cnt;
			unf_ff <= (unf_ff && !fifo_clear) || pop_empty;
			ovr_ff <= (ovr_ff && !fifo_clear) || push_full;
		end
	end
	// ----------------------------------------------------------------
	// last byte info, captured at frame end
	// ----------------------------------------------------------------
	logic [2:0] lb_bits_ff;
	logic parity_absent_ff;
	logic hard_err_ff;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			lb_bits_ff <= 3'h0;
			parity_absent_ff <= 1'b0;
			hard_err_ff <= 1'b0;
		end else if (rx_frame_end) begin
			lb_bits_ff <= last_byte_bit_count;
			parity_absent_ff <= last_byte_parity_absent && (last_byte_bit_count == 3'h0);
			hard_err_ff <= hard_framing_error_flag;
		end else if (rx_frame_start) begin
			hard_err_ff <= 1'b0;
		end
	end
	// ----------------------------------------------------------------
	// collision position, only inside anticollision frames
	// ----------------------------------------------------------------
	col_state_t col_state_ff;
	col_state_t nxt_col_state;
	logic [7:0] coll_ff;
	wire col_in_frame = col_state_ff == col_frame;
	// hard framing errors count as collisions too; both are dropped outside the frame
	wire col_hit = col_in_frame && (collision_detect || hard_framing_error_flag);
	wire [7:0] col_word = {collision_byte_index, collision_bit_index, collision_on_parity_flag};
	always_comb begin
		nxt_col_state = col_state_ff;
		unique case (col_state_ff)
			col_idle: begin
				if (rx_frame_start && anticollision_frame) begin
					nxt_col_state = col_frame;
				end
			end
			col_frame: begin
				if (rx_frame_end) begin
					nxt_col_state = col_idle;
				end else if (col_hit) begin
					nxt_col_state = col_done;
				end
			end
			col_done: begin
				if (rx_frame_end) begin
					nxt_col_state = col_idle;
				end
			end
		endcase
	end
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			col_state_ff <= col_idle;
			coll_ff <= BYTE_RST;
		end else begin
			col_state_ff <= nxt_col_state;
			// first collision only; later ones in the same frame are ignored
			if (col_hit) begin
				coll_ff <= col_word;
			end
		end
	end
	// ----------------------------------------------------------------
	// register views and bus
	// ----------------------------------------------------------------
	// fields below stay whatever last capture left when hard error is set
	wire [7:0] fifo_lo_view = cnt_ff[7:0];
	wire [7:0] fifo_hi_view = {cnt_ff[9:8], unf_ff, ovr_ff, lb_bits_ff, parity_absent_ff};
	nfc_rx_status_apb u_apb (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.irq_val(irq_ff),
		.fifo_lo_val(fifo_lo_view),
		.fifo_hi_val(fifo_hi_view),
		.coll_val(coll_ff),
		.ctrl_val(evt_en_ff),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.irq_read_pulse(irq_read),
		.ctrl_wr_pulse(ctrl_wr)
	);
	logic hard_err_out_ff;
	logic [7:0] irq_out_ff;
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			hard_err_out_ff <= 1'b0;
			irq_out_ff <= IRQ_RST;
		end else begin
			hard_err_out_ff <= hard_err_ff;
			irq_out_ff <= irq_ff;
		end
	end
	assign status_hard_error = hard_err_out_ff;
	assign irq_pending = irq_out_ff;
endmodule : nfc_rx_status_irq_regs
`default_nettype wire

/* File: nfc_rx_status_irq_regs_monitor.sv */
// checker: bus timing and event flag relations of the rx status bank
`timescale 1ns/1ps
`default_nettype none
module nfc_rx_status_irq_regs_monitor
	import nfc_rx_status_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic second_field_wait_timer_expired,
	input wire logic [7:0] free_time_slot_number_count,
	input wire logic field_on_no_collision,
	input wire logic rx_end_auto_answered,
	input wire logic sensf_auto_response_sent,
	input wire logic target_reached_active_star,
	input wire logic target_reached_active,
	input wire logic [7:0] irq_pending
);
	wire logic [7:0] ev = {second_field_wait_timer_expired, 1'b0, field_on_no_collision, rx_end_auto_answered,
		sensf_auto_response_sent, 1'b0, target_reached_active_star, target_reached_active};
	// a read only proves the clear when no new event can land on top of it
	wire logic quiet = ev == 8'h00 && free_time_slot_number_count != SLOT_WL_LEVEL;
	wire logic mapped = paddr inside {OFF_PT_IRQ, OFF_FIFO_LO, OFF_FIFO_HI, OFF_COLL, OFF_EVT_CTRL};
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	sequence irq_read;
		psel && penable && pready && !pwrite && paddr == OFF_PT_IRQ && quiet ##1 quiet;
	endsequence
	read_clears_a: assert property (irq_read |=> irq_pending == 8'h00) else $error("event bits kept");
	event_sets_a: assert property (ev != 8'h00 |-> ##2 (irq_pending & $past(ev, 2)) == $past(ev, 2))
		else $error("event not latched");
	slot_level_a: assert property (free_time_slot_number_count == SLOT_WL_LEVEL
		&& $past(free_time_slot_number_count) != SLOT_WL_LEVEL |-> ##2 irq_pending[6]) else $error("slot level lost");
	reserved_bit_a: assert property (irq_pending[2] == 1'b0) else $error("reserved bit set");
	wait_state_a: assert property (psel && penable && !pready |=> pready) else $error("no answer");
	ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
	write_ok_a: assert property (pready && mapped |-> !pslverr) else $error("error on mapped access");
	bad_addr_a: assert property (pslverr |-> pready && prdata == 32'h0 && !mapped) else $error("bad error");
endmodule : nfc_rx_status_irq_regs_monitor
bind nfc_rx_status_irq_regs nfc_rx_status_irq_regs_monitor u_mon (.core_clk, .rst_b, .psel, .penable, .pwrite,
	.paddr, .prdata, .pready, .pslverr, .second_field_wait_timer_expired, .free_time_slot_number_count,
	.field_on_no_collision, .rx_end_auto_answered, .sensf_auto_response_sent, .target_reached_active_star,
	.target_reached_active, .irq_pending);
`default_nettype wire

/* File: nfc_rx_status_irq_regs_test.sv */
// testbench: event clear on read, fifo count, last byte and collision capture
`timescale 1ns/1ps
`default_nettype none
module nfc_rx_status_irq_regs_test
	import nfc_rx_status_pkg::*;
;
	logic core_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e, pready, pslverr;
	logic fifo_push = 1'b0, fifo_pop = 1'b0, fifo_clear = 1'b0, rx_frame_start = 1'b0, rx_frame_end = 1'b0;
	logic anticollision_frame = 1'b0, last_byte_parity_absent = 1'b0, hard_framing_error_flag = 1'b0;
	logic collision_detect = 1'b0, collision_on_parity_flag = 1'b0, status_hard_error;
	logic [2:0] last_byte_bit_count = 3'h0, collision_bit_index = 3'h0;
	logic [3:0] collision_byte_index = 4'h0, pstrb = 4'hF;
	logic [5:0] ev = 6'h00;
	logic [7:0] free_time_slot_number_count = 8'h10, irq_pending;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, q;
	int errors = 0, check_count = 0;
	int bp[6] = '{0, 1, 3, 4, 5, 7};
	always #50 core_clk = ~core_clk;
	nfc_rx_status_irq_regs u_nfc_rx_status_irq_regs (.core_clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb, .prdata, .pready, .pslverr, .second_field_wait_timer_expired(ev[5]), .free_time_slot_number_count,
		.field_on_no_collision(ev[4]), .rx_end_auto_answered(ev[3]), .sensf_auto_response_sent(ev[2]),
		.target_reached_active_star(ev[1]), .target_reached_active(ev[0]), .fifo_push, .fifo_pop, .fifo_clear,
		.rx_frame_start, .rx_frame_end, .anticollision_frame, .last_byte_bit_count, .last_byte_parity_absent,
		.hard_framing_error_flag, .collision_detect, .collision_byte_index, .collision_bit_index,
		.collision_on_parity_flag, .status_hard_error, .irq_pending);
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("mismatch at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge core_clk);
		penable <= 1'b1;
		@(posedge core_clk);
		while (pready !== 1'b1) @(posedge core_clk);
		{q, e} = {prdata, pslverr};
		{psel, penable} <= 2'b00;
		@(posedge core_clk);
	endtask : xfer
	task automatic rc(input logic [11:0] a, input logic [31:0] x);
		xfer(1'b0, a, 32'h0);
		chk(q, x);
	endtask : rc
	// second collision in the same frame carries inverted indices and must be ignored
	task automatic frame(input logic ac, input logic [7:0] col, input logic [4:0] tail);
		{anticollision_frame, rx_frame_start} <= {ac, 1'b1};
		@(posedge core_clk);
		{rx_frame_start, collision_detect, collision_byte_index, collision_bit_index,
			collision_on_parity_flag} <= {1'b0, col != 8'h00, col};
		@(posedge core_clk);
		{collision_byte_index, collision_bit_index, collision_on_parity_flag} <= ~col;
		@(posedge core_clk);
		{collision_detect, rx_frame_end, last_byte_bit_count, last_byte_parity_absent,
			hard_framing_error_flag} <= {2'b01, tail};
		@(posedge core_clk);
		rx_frame_end <= 1'b0;
		@(posedge core_clk);
	endtask : frame
	task automatic wrap_up;
		if (errors == 0 && check_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : wrap_up
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		repeat (8) @(posedge core_clk);
		rst_b <= 1'b1;
		@(posedge core_clk);
		rc(OFF_PT_IRQ, 32'h0);
		for (int i = 0; i < 6; i++) begin
			ev <= 6'h01 << i;
			@(posedge core_clk);
			ev <= 6'h00;
			@(posedge core_clk);
			rc(OFF_PT_IRQ, 32'h1 << bp[i]);
			rc(OFF_PT_IRQ, 32'h0);
		end
		free_time_slot_number_count <= 8'h05;
		rc(OFF_PT_IRQ, 32'h0);
		free_time_slot_number_count <= 8'h04;
		rc(OFF_PT_IRQ, 32'h40);
		rc(OFF_PT_IRQ, 32'h0);
		{free_time_slot_number_count, ev} <= {8'h10, 6'h3F};
		@(posedge core_clk);
		ev <= 6'h00;
		xfer(1'b1, OFF_PT_IRQ, 32'h0);
		chk(32'(e), 32'h0);
		chk(32'(irq_pending), 32'hBB);
		rc(OFF_PT_IRQ, 32'hBB);
		xfer(1'b0, 12'h004, 32'h0);
		chk(q, 32'h0);
		chk(32'(e), 32'h1);
		xfer(1'b1, OFF_EVT_CTRL, 32'hFF);
		rc(OFF_EVT_CTRL, 32'hFB);
		fifo_push <= 1'b1;
		repeat (514) @(posedge core_clk);
		fifo_push <= 1'b0;
		rc(OFF_FIFO_LO, 32'h00);
		rc(OFF_FIFO_HI, 32'h90);
		fifo_pop <= 1'b1;
		repeat (3) @(posedge core_clk);
		fifo_pop <= 1'b0;
		rc(OFF_FIFO_LO, 32'hFD);
		rc(OFF_FIFO_HI, 32'h50);
		fifo_clear <= 1'b1;
		@(posedge core_clk);
		{fifo_clear, fifo_pop} <= 2'b01;
		@(posedge core_clk);
		fifo_pop <= 1'b0;
		rc(OFF_FIFO_HI, 32'h20);
		fifo_clear <= 1'b1;
		@(posedge core_clk);
		fifo_clear <= 1'b0;
		frame(1'b1, 8'h3B, 5'b10100);
		rc(OFF_COLL, 32'h3B);
		rc(OFF_FIFO_HI, 32'h0A);
		frame(1'b0, 8'h52, 5'b00010);
		rc(OFF_COLL, 32'h3B);
		rc(OFF_FIFO_HI, 32'h01);
		frame(1'b1, 8'h52, 5'b00000);
		xfer(1'b1, OFF_COLL, 32'hFF);
		rc(OFF_COLL, 32'h52);
		frame(1'b0, 8'h00, 5'b00001);
		@(posedge core_clk);
		chk(32'(status_hard_error), 32'h1);
		frame(1'b0, 8'h00, 5'b00000);
		chk(32'(status_hard_error), 32'h0);
		wrap_up();
	end
	initial begin
		#2000000;
		errors++;
		wrap_up();
	end
endmodule : nfc_rx_status_irq_regs_test
`default_nettype wire

/* File: nfc_rx_status_pkg.sv */
// package: offsets, field positions, reset values and widths of the rx status bank
package nfc_rx_status_pkg;
	// register numbers are word indices; the bus carries byte addresses, four per index
	localparam logic [9:0] IDX_PT_IRQ = 10'h01D;
	localparam logic [9:0] IDX_FIFO_LO = 10'h01E;
	localparam logic [9:0] IDX_FIFO_HI = 10'h01F;
	localparam logic [9:0] IDX_COLL = 10'h020;
	localparam logic [11:0] OFF_PT_IRQ = {IDX_PT_IRQ, 2'b00};
	localparam logic [11:0] OFF_FIFO_LO = {IDX_FIFO_LO, 2'b00};
	localparam logic [11:0] OFF_FIFO_HI = {IDX_FIFO_HI, 2'b00};
	localparam logic [11:0] OFF_COLL = {IDX_COLL, 2'b00};
	localparam logic [11:0] OFF_EVT_CTRL = 12'h100;
	localparam int BIT_FIELD_TIMER = 7;
	localparam int BIT_SLOT_WL = 6;
	localparam int BIT_APON = 5;
	localparam int BIT_RXE_PTA = 4;
	localparam int BIT_WU_F = 3;
	localparam int BIT_WU_ASTAR = 1;
	localparam int BIT_WU_A = 0;
	localparam int FIFO_CNT_W = 10;
	localparam logic [9:0] FIFO_CNT_MAX = 10'h200;
	localparam int SLOT_CNT_W = 8;
	localparam logic [7:0] SLOT_WL_LEVEL = 8'h04;
	localparam logic [7:0] IRQ_RST = 8'h00;
	localparam logic [7:0] BYTE_RST = 8'h00;
	localparam logic [9:0] CNT_RST = 10'h000;
	localparam int FRAME_BYTES_MAX = 15;
	typedef enum logic [1:0] {
		col_idle,
		col_frame,
		col_done
	} col_state_t;
endpackage : nfc_rx_status_pkg
